// [tb/obt_break_trace_asserts.sv]
// checker of halt, match interrupt and trace counting
`default_nettype none
module obt_break_trace_asserts #(
   parameter int unsigned TRACE_DEP = 64          // trace entries
) (
   input wire logic                       clk,         // cpu clock
   input wire logic                       srst,        // sync reset
   input wire logic                       force_req,   // halt request
   input wire logic                       resume,      // restart
   input wire logic                       br_valid,    // branch taken
   input wire logic                       trc_en,      // trace on
   input wire logic                       trc_mode,    // 1 data
   input wire logic                       full_stop_en, // halt on full
   input wire logic                       halted,      // core halted
   input wire logic                       amatch_irq,  // match irq
   input wire logic [2:0]                 halt_cause,  // halt cause
   input wire logic                       trc_full,    // buffer full
   input wire logic [$clog2(TRACE_DEP):0] trc_count    // entries
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // halt sources and trace counter
   // ****
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_force;
      !halted && force_req |=> halted && halt_cause == 3'h1;
   endproperty
   a_force: assert property (p_force) else $error("no forced halt");
   // a match interrupt only ever comes with the halt it causes
   property p_irq; amatch_irq |-> $rose(halted) && halt_cause == 3'h3;
   endproperty
   a_irq: assert property (p_irq) else $error("stray match irq");
   property p_hold; halted && !resume |=> halted; endproperty
   a_hold: assert property (p_hold) else $error("halt dropped");
   property p_resume; halted && resume |=> !halted; endproperty
   a_resume: assert property (p_resume) else $error("no restart");
   property p_full; trc_full && full_stop_en && !halted |=> halted;
   endproperty
   a_full: assert property (p_full) else $error("no full halt");
   property p_flag; trc_full == (trc_count == TRACE_DEP); endproperty
   a_flag: assert property (p_flag) else $error("full flag wrong");
   property p_frozen; halted |=> $stable(trc_count); endproperty
   a_frozen: assert property (p_frozen) else $error("trace moved");
   property p_branch;
      !halted && trc_en && !trc_mode && br_valid && !trc_full
         |=> trc_count == $past(trc_count) + 1'b1;
   endproperty
   a_branch: assert property (p_branch) else $error("branch lost");
   // branch mode ignores data accesses entirely
   property p_mode; !trc_mode && !br_valid |=> $stable(trc_count);
   endproperty
   a_mode: assert property (p_mode) else $error("mode mixed");
   c_force: cover property (!halted && force_req);
   c_irq: cover property (amatch_irq);
   c_full: cover property (trc_full && halted);
endmodule : obt_break_trace_asserts
bind obt_break_trace obt_break_trace_asserts #(.TRACE_DEP(TRACE_DEP)) i_chk (
   .clk, .srst, .force_req, .resume, .br_valid, .trc_en, .trc_mode,
   .full_stop_en, .halted, .amatch_irq, .halt_cause, .trc_full, .trc_count);
`default_nettype wire

// [tb/obt_break_trace_tb.sv]
// self-checking bench of the break and trace unit
`default_nettype none
module obt_break_trace_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned DEP = 8;  // short buffer keeps the fill quick
   localparam int unsigned AW  = obt_pkg::ADDR_W;
   logic clk = 0, srst = 1, force_req = 0, resume = 0, trap_exec;
   logic fetch_valid = 0, acc_valid = 0, acc_write = 0, acc_word = 0;
   logic br_valid = 0, ea_en = 0, eb_en = 0, stop_en = 0, full_stop_en = 0;
   logic trc_en = 0, trc_mode = 0, halted, amatch_irq, trc_full;
   logic [AW-1:0] fetch_addr = '0, acc_addr = '0, br_src = '0, br_dst = '0;
   logic [AW-1:0] ea_addr = '0, eb_addr = '0;
   logic [7:0] amatch_en = '0;
   logic [8*AW-1:0] amatch_addr = '0;
   logic [15:0] acc_data = '0, ea_data = '0, ea_dmask = '0;
   logic [obt_pkg::MASK_W-1:0] ea_amask = '0, eb_amask = '0;
   logic [1:0] ea_dir = '0, ea_size = '0, eb_dir = '0, eb_size = '0;
   logic [2:0] stop_sel = '0, halt_cause, trc_rd_idx = '0;
   logic [3:0] trc_count;
   logic [47:0] trc_rd_data;
   int error_cnt = 0, total_checks = 0, cyc = 0;
   obt_break_trace #(.TRACE_DEP(DEP)) i_obt_break_trace (
      .clk, .srst, .force_req, .resume, .trap_exec, .fetch_addr,
      .fetch_valid, .amatch_en, .amatch_addr, .acc_addr, .acc_data,
      .acc_valid, .acc_write, .acc_word, .br_valid, .br_src, .br_dst,
      .ea_en, .ea_addr, .ea_amask, .ea_data, .ea_dmask, .ea_dir, .ea_size,
      .eb_en, .eb_addr, .eb_amask, .eb_dir, .eb_size, .stop_en, .stop_sel,
      .full_stop_en, .trc_en, .trc_mode, .trc_rd_idx, .halted, .amatch_irq,
      .halt_cause, .trc_full, .trc_count, .trc_rd_data);
   obt_emu_model i_obt_emu_model (
      .clk, .halted, .fetch_addr, .fetch_valid, .trap_exec);
   always #50 clk = ~clk;
   // ****
   // shared tasks
   // ****
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic restart();
      @(posedge clk) resume <= 1'b1;
      @(posedge clk) resume <= 1'b0;
      #1 check(halted, 1'b0);
   endtask : restart
   // one halt outcome, then back to running so the next case starts clean
   task automatic judge(input logic [2:0] cause);
      #1 check(halted, cause != 3'h0);
      check(amatch_irq, cause == 3'h3);
      if (cause != 3'h0) begin
         check(halt_cause, cause);
         restart();
      end
   endtask : judge
   task automatic fetch(input logic [AW-1:0] a, input logic [2:0] cause);
      @(posedge clk);
      fetch_addr <= a;
      fetch_valid <= 1'b1;
      @(posedge clk) fetch_valid <= 1'b0;
      judge(cause);
   endtask : fetch
   task automatic access(input logic [AW-1:0] a, input logic [15:0] d,
                         input logic wr, input logic wd, input logic hit);
      @(posedge clk);
      acc_addr <= a;
      acc_data <= d;
      acc_write <= wr;
      acc_word <= wd;
      acc_valid <= 1'b1;
      @(posedge clk) acc_valid <= 1'b0;
      judge(hit ? 3'h4 : 3'h0);
   endtask : access
   task automatic branch(input logic [AW-1:0] s);
      @(posedge clk);
      br_src <= s;
      br_dst <= s + 24'h000100;
      br_valid <= 1'b1;
      @(posedge clk) br_valid <= 1'b0;
   endtask : branch
   task automatic read_entry(input logic [2:0] i, input logic [47:0] exp);
      @(posedge clk) trc_rd_idx <= i;
      @(posedge clk);
      #1 check(trc_rd_data, exp);
   endtask : read_entry
   // ****
   // scenarios
   // ****
   task automatic t_force_trap();
      @(posedge clk) force_req <= 1'b1;
      @(posedge clk) force_req <= 1'b0;
      #1 check(halt_cause, 3'h1);
      i_obt_emu_model.set_bp(4'h5);
      restart();
      fetch(24'h000005, 3'h2);
      i_obt_emu_model.clr_bp(4'h5);
      restart();
      // the real opcode now runs at the old stop address
      fetch(24'h000005, 3'h0);
   endtask : t_force_trap
   task automatic t_addr();
      @(posedge clk);
      amatch_addr[7*AW +: AW] <= 24'h000123;
      amatch_en <= 8'h80;
      fetch(24'h000123, 3'h3);
      @(posedge clk) amatch_en <= 8'h7F;
      fetch(24'h000123, 3'h0);
   endtask : t_addr
   task automatic t_event();
      @(posedge clk);
      {ea_en, eb_en, stop_en} <= 3'h7;
      ea_addr <= 24'h000420;
      ea_data <= 16'h0012;
      ea_dmask <= 16'h00FF;
      ea_dir <= obt_pkg::DIR_WRITE;
      ea_size <= obt_pkg::SIZE_WORD;
      eb_addr <= 24'h000400;
      eb_amask <= 5'h02;
      eb_dir <= obt_pkg::DIR_READ;
      eb_size <= obt_pkg::SIZE_BYTE;
      stop_sel <= obt_pkg::STOP_A;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b1);
      access(24'h000420, 16'h3413, 1'b1, 1'b1, 1'b0);
      access(24'h000420, 16'h3412, 1'b0, 1'b1, 1'b0);
      access(24'h000420, 16'h3412, 1'b1, 1'b0, 1'b0);
      @(posedge clk) stop_sel <= obt_pkg::STOP_A_OR;
      access(24'h000403, 16'h0000, 1'b0, 1'b0, 1'b1);
      access(24'h000404, 16'h0000, 1'b0, 1'b0, 1'b0);
      access(24'h000400, 16'h0000, 1'b0, 1'b1, 1'b0);
      @(posedge clk) stop_sel <= obt_pkg::STOP_A_AND;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
      access(24'h000400, 16'h0000, 1'b0, 1'b0, 1'b1);
      // the restart cleared the b seen before, so a alone must not stop
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
      @(posedge clk) stop_sel <= obt_pkg::STOP_B_A;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
      access(24'h000400, 16'h0000, 1'b0, 1'b0, 1'b0);
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b1);
      @(posedge clk) stop_sel <= obt_pkg::STOP_NONE;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
      @(posedge clk) stop_sel <= obt_pkg::STOP_A;
      stop_en <= 1'b0;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
   endtask : t_event
   task automatic t_trace();
      @(posedge clk) {trc_en, trc_mode} <= 2'h3;
      access(24'h000420, 16'h3412, 1'b1, 1'b1, 1'b0);
      access(24'h000500, 16'h3412, 1'b1, 1'b1, 1'b0);
      branch(24'h000010);
      #1 check(trc_count, 4'h1);
      read_entry(3'h0, 48'h000420_00_3412);
      @(posedge clk) trc_mode <= 1'b0;
      branch(24'h000020);
      read_entry(3'h1, 48'h000020_000120);
      @(posedge clk) full_stop_en <= 1'b1;
      repeat (7) branch(24'h000030);
      #1 check(trc_count, 4'h8);
      check(trc_full, 1'b1);
      check(halt_cause, 3'h5);
   endtask : t_trace
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_force_trap();
      t_addr();
      t_event();
      t_trace();
      summarize();
   end
endmodule : obt_break_trace_tb
`default_nettype wire

// [tb/obt_emu_model.sv]
// emulator probe model: program opcodes patched with trap opcodes
`default_nettype none
module obt_emu_model (
   input  wire logic                       clk,         // cpu clock
   input  wire logic                       halted,      // core halted
   input  wire logic [obt_pkg::ADDR_W-1:0] fetch_addr,  // fetch address
   input  wire logic                       fetch_valid, // fetch strobe
   output logic                            trap_exec    // trap executed
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [16];    // small program store
   logic [7:0] saved [16];  // opcodes hidden under traps
   int         nbp = 0;     // traps in place
   initial foreach (mem[i]) mem[i] = 8'h40;
   // the core reports a trap when it fetches a patched opcode
   assign trap_exec = fetch_valid && !halted
                      && mem[fetch_addr[3:0]] === obt_pkg::TRAP_OPCODE;
   // patching a running core is refused, as on the real probe
   task automatic set_bp(input logic [3:0] a);
      if (halted && nbp < 255) begin
         saved[a] = mem[a];
         mem[a] = obt_pkg::TRAP_OPCODE;
         nbp++;
      end
   endtask : set_bp
   task automatic clr_bp(input logic [3:0] a);
      mem[a] = saved[a];
      nbp--;
   endtask : clr_bp
endmodule : obt_emu_model
`default_nettype wire

// [verilog/obt_break_trace.sv]
// on-chip break and trace unit top
`default_nettype none
module obt_break_trace #(
   parameter int unsigned NUM_CMP   = obt_pkg::NUM_CMP,   // address comparators
   parameter int unsigned TRACE_DEP = obt_pkg::TRACE_DEP  // trace entries
) (
   input  wire logic                        clk,          // 10 MHz cpu clock
   input  wire logic                        srst,         // sync reset
   input  wire logic                        force_req,    // emulator halt pulse
   input  wire logic                        resume,       // restart pulse
   input  wire logic                        trap_exec,    // trap opcode hit
   input  wire logic [obt_pkg::ADDR_W-1:0]  fetch_addr,   // next fetch address
   input  wire logic                        fetch_valid,  // fetch this cycle
   input  wire logic [NUM_CMP-1:0]          amatch_en,    // comparator arms
   input  wire logic [NUM_CMP*obt_pkg::ADDR_W-1:0] amatch_addr, // cmp addrs
   input  wire logic [obt_pkg::ADDR_W-1:0]  acc_addr,     // data bus address
   input  wire logic [obt_pkg::DATA_W-1:0]  acc_data,     // data bus data
   input  wire logic                        acc_valid,    // data access
   input  wire logic                        acc_write,    // write access
   input  wire logic                        acc_word,     // word access
   input  wire logic                        br_valid,     // branch taken
   input  wire logic [obt_pkg::ADDR_W-1:0]  br_src,       // branch source
   input  wire logic [obt_pkg::ADDR_W-1:0]  br_dst,       // branch target
   input  wire logic                        ea_en,        // event a enable
   input  wire logic [obt_pkg::ADDR_W-1:0]  ea_addr,      // event a address
   input  wire logic [obt_pkg::MASK_W-1:0]  ea_amask,     // event a addr mask
   input  wire logic [obt_pkg::DATA_W-1:0]  ea_data,      // event a data
   input  wire logic [obt_pkg::DATA_W-1:0]  ea_dmask,     // event a data mask
   input  wire logic [1:0]                  ea_dir,       // event a direction
   input  wire logic [1:0]                  ea_size,      // event a size
   input  wire logic                        eb_en,        // event b enable
   input  wire logic [obt_pkg::ADDR_W-1:0]  eb_addr,      // event b address
   input  wire logic [obt_pkg::MASK_W-1:0]  eb_amask,     // event b addr mask
   input  wire logic [1:0]                  eb_dir,       // event b direction
   input  wire logic [1:0]                  eb_size,      // event b size
   input  wire logic                        stop_en,      // break cond enable
   input  wire logic [2:0]                  stop_sel,     // break selector
   input  wire logic                        full_stop_en, // break on full
   input  wire logic                        trc_en,       // trace enable
   input  wire logic                        trc_mode,     // 0 branch, 1 data
   input  wire logic [$clog2(TRACE_DEP)-1:0] trc_rd_idx,  // trace read index
   output logic                             halted,       // cpu halted
   output logic                             amatch_irq,   // match interrupt
   output logic [2:0]                       halt_cause,   // last halt cause
   output logic                             trc_full,     // buffer full
   output logic [$clog2(TRACE_DEP):0]       trc_count,    // entries stored
   output logic [2*obt_pkg::ADDR_W-1:0]     trc_rd_data   // entry read out
);
   localparam int unsigned IDX_W = $clog2(TRACE_DEP);
   localparam int unsigned ENT_W = 2 * obt_pkg::ADDR_W;
   localparam logic [2:0] CAUSE_FORCE = 3'h1;
   localparam logic [2:0] CAUSE_TRAP  = 3'h2;
   localparam logic [2:0] CAUSE_ADDR  = 3'h3;
   localparam logic [2:0] CAUSE_EVENT = 3'h4;
   localparam logic [2:0] CAUSE_FULL  = 3'h5;
   localparam logic [IDX_W:0] DEPTH = (IDX_W+1)'(TRACE_DEP);

   // ************************************************************
   // event comparators
   // ************************************************************
   obt_cmp_if ia ();
   obt_cmp_if ib ();
   // both share the data bus; event b never checks data
   assign ia.acc_addr  = acc_addr;
   assign ia.acc_data  = acc_data;
   assign ia.acc_valid = acc_valid && !halted;
   assign ia.acc_write = acc_write;
   assign ia.acc_word  = acc_word;
   assign ia.en        = ea_en;
   assign ia.addr      = ea_addr;
   assign ia.amask     = ea_amask;
   assign ia.data      = ea_data;
   assign ia.dmask     = ea_dmask;
   assign ia.dir       = ea_dir;
   assign ia.size      = ea_size;
   assign ib.acc_addr  = acc_addr;
   assign ib.acc_data  = acc_data;
   assign ib.acc_valid = acc_valid && !halted;
   assign ib.acc_write = acc_write;
   assign ib.acc_word  = acc_word;
   assign ib.en        = eb_en;
   assign ib.addr      = eb_addr;
   assign ib.amask     = eb_amask;
   assign ib.data      = '0;
   assign ib.dmask     = '0;
   assign ib.dir       = eb_dir;
   assign ib.size      = eb_size;

   obt_event_cmp #(.USE_DATA(1'b1)) u_cmp_a (.c(ia));
   obt_event_cmp #(.USE_DATA(1'b0)) u_cmp_b (.c(ib));

   // ************************************************************
   // address match comparators
   // ************************************************************
   logic [NUM_CMP-1:0] amatch_hit;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++) begin : g_am
         // compare before execution; flash is never touched
         assign amatch_hit[gi] = amatch_en[gi] && fetch_valid &&
            (fetch_addr == amatch_addr[gi*obt_pkg::ADDR_W +:
                                       obt_pkg::ADDR_W]);
      end
   endgenerate

   // ************************************************************
   // halt control and event combination
   // ************************************************************
   obt_pkg::obt_state_t state;
   obt_pkg::obt_state_t next_state;
   logic       seen_a;
   logic       seen_b;
   logic       next_seen_a;
   logic       next_seen_b;
   logic       next_halted;
   logic       next_irq;
   logic [2:0] next_cause;
   logic       ev_stop;
   logic       any_am;
   logic       full_now;

   // combine events; any armed source may halt, cause by priority force, trap, match, event, full
   always_comb begin
      any_am      = |amatch_hit;
      next_seen_a = seen_a || ia.hit;
      next_seen_b = seen_b || ib.hit;
      case (stop_sel)
         obt_pkg::STOP_A:     ev_stop = ia.hit;
         obt_pkg::STOP_A_OR:  ev_stop = ia.hit || ib.hit;
         obt_pkg::STOP_A_AND: ev_stop = next_seen_a && next_seen_b;
         obt_pkg::STOP_B_A:   ev_stop = ia.hit && seen_b; // b strictly first
         default:             ev_stop = 1'b0;
      endcase
      ev_stop    = ev_stop && stop_en;
      full_now   = full_stop_en && trc_full;
      next_state = state;
      next_irq   = 1'b0;
      next_cause = halt_cause;
      case (state)
         obt_pkg::OBT_RUN: begin
            if (force_req || trap_exec || any_am || ev_stop || full_now) begin
               next_state = obt_pkg::OBT_HALT;
               // the interrupt only flags a halt that the match itself won
               next_irq   = any_am && !force_req && !trap_exec;
               if (force_req)      next_cause = CAUSE_FORCE;
               else if (trap_exec) next_cause = CAUSE_TRAP;
               else if (any_am)    next_cause = CAUSE_ADDR;
               else if (ev_stop)   next_cause = CAUSE_EVENT;
               else                next_cause = CAUSE_FULL;
            end
         end
         obt_pkg::OBT_HALT: begin
            // the emulator steps the real instruction itself
            if (resume) begin
               next_state  = obt_pkg::OBT_RUN;
               next_seen_a = 1'b0;
               next_seen_b = 1'b0;
            end
         end
         default: next_state = obt_pkg::OBT_HALT;
      endcase
      next_halted = (next_state == obt_pkg::OBT_HALT);
   end

   // halt state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         state      <= obt_pkg::OBT_RUN;
         halted     <= 1'b0;
         amatch_irq <= 1'b0;
         halt_cause <= 3'h0;
         seen_a     <= 1'b0;
         seen_b     <= 1'b0;
      end else begin
         state      <= next_state;
         halted     <= next_halted;
         amatch_irq <= next_irq;
         halt_cause <= next_cause;
         seen_a     <= next_seen_a;
         seen_b     <= next_seen_b;
      end
   end

   // ************************************************************
   // trace buffer
   // ************************************************************
   logic [ENT_W-1:0] trc_mem [TRACE_DEP];
   logic [IDX_W:0]   next_count;
   logic             wr_en;
   logic [ENT_W-1:0] wr_ent;

   // one mode at a time; buffer stops when full rather than wrap
   always_comb begin
      if (trc_mode) begin
         wr_en  = ia.hit || ib.hit;
         wr_ent = {acc_addr, {(obt_pkg::ADDR_W-obt_pkg::DATA_W){1'b0}},
                   acc_data};
      end else begin
         wr_en  = br_valid && !halted;
         wr_ent = {br_src, br_dst};
      end
      wr_en      = wr_en && trc_en && (trc_count != DEPTH);
      next_count = trc_count + (IDX_W+1)'(wr_en);
   end

   // entry storage and fill level
   always_ff @(posedge clk) begin
      if (wr_en) trc_mem[trc_count[IDX_W-1:0]] <= wr_ent;
      if (srst) begin
         trc_count   <= '0;
         trc_full    <= 1'b0;
         trc_rd_data <= '0;
      end else begin
         trc_count   <= next_count;
         trc_full    <= (next_count == DEPTH);
         trc_rd_data <= trc_mem[trc_rd_idx];
      end
   end
endmodule : obt_break_trace
`default_nettype wire

// [verilog/obt_cmp_if.sv]
// interface carrying one data access and an event comparator setup
`default_nettype none
interface obt_cmp_if;
   logic [obt_pkg::ADDR_W-1:0] acc_addr;   // access address
   logic [obt_pkg::DATA_W-1:0] acc_data;   // access data
   logic                       acc_valid;  // access this cycle
   logic                       acc_write;  // 1 write, 0 read
   logic                       acc_word;   // 1 word, 0 byte
   logic                       en;         // comparator enable
   logic [obt_pkg::ADDR_W-1:0] addr;       // compare address
   logic [obt_pkg::MASK_W-1:0] amask;      // low bits ignored
   logic [obt_pkg::DATA_W-1:0] data;       // compare data
   logic [obt_pkg::DATA_W-1:0] dmask;      // data mask, zero off
   logic [1:0]                 dir;        // direction select
   logic [1:0]                 size;       // size select
   logic                       hit;        // comparator match
   modport cmp (input acc_addr, acc_data, acc_valid, acc_write, acc_word,
                en, addr, amask, data, dmask, dir, size, output hit);
   modport top (output acc_addr, acc_data, acc_valid, acc_write, acc_word,
                en, addr, amask, data, dmask, dir, size, input hit);
endinterface : obt_cmp_if
`default_nettype wire

// [verilog/obt_event_cmp.sv]
// data access event comparator, combinational
`default_nettype none
module obt_event_cmp #(
   parameter bit USE_DATA = 1'b1           // compare data as well
) (
   obt_cmp_if.cmp c                        // access and setup
);
   logic [obt_pkg::ADDR_W-1:0] amask_bits;
   logic                       a_ok;
   logic                       d_ok;
   logic                       dir_ok;
   logic                       size_ok;

   // address, data, direction and size qualifiers combined
   always_comb begin
      amask_bits = ~(({obt_pkg::ADDR_W{1'b1}}) << c.amask);
      a_ok = ((c.acc_addr ^ c.addr) & ~amask_bits) == '0;
      // a zero mask means data is not compared
      d_ok = !USE_DATA || (((c.acc_data ^ c.data) & c.dmask) == '0);
      case (c.dir)
         obt_pkg::DIR_READ:  dir_ok = !c.acc_write;
         obt_pkg::DIR_WRITE: dir_ok = c.acc_write;
         default:            dir_ok = 1'b1;
      endcase
      case (c.size)
         obt_pkg::SIZE_BYTE: size_ok = !c.acc_word;
         obt_pkg::SIZE_WORD: size_ok = c.acc_word && !c.addr[0];
         default:            size_ok = 1'b1;
      endcase
      c.hit = c.en && c.acc_valid && a_ok && d_ok && dir_ok && size_ok;
   end
endmodule : obt_event_cmp
`default_nettype wire

// [verilog/obt_pkg.sv]
// package of constants and types for the on-chip break and trace unit
//
// Operation
// - break sources armed singly or together
// - forced halt request stops program unconditionally
// - halt before fetch matching armed comparator
// - address halt via match interrupt, not memory
// - event a compares address and data
// - event b address only, combinable
// - halt when trace buffer fills, if armed
// - trace mode is branch or data
// - branch entry holds source and destination
// - data trace records only matching accesses
// - each comparator and condition has enable
// - direction qualifier read, write or either
// - low address bits masked, zero data mask
// - size qualifier byte or word
// - break select none, a, a|b, a&b, b->a
`default_nettype none
package obt_pkg;
   localparam int unsigned ADDR_W    = 24;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned NUM_CMP   = 8;
   localparam int unsigned MASK_W    = 5;
   localparam int unsigned TRACE_DEP = 64;
   // debug trap opcode value, arbitrary
   localparam logic [7:0]  TRAP_OPCODE = 8'h00;
   localparam logic [1:0]  DIR_RW    = 2'h0;
   localparam logic [1:0]  DIR_READ  = 2'h1;
   localparam logic [1:0]  DIR_WRITE = 2'h2;
   localparam logic [1:0]  SIZE_ANY  = 2'h0;
   localparam logic [1:0]  SIZE_BYTE = 2'h1;
   localparam logic [1:0]  SIZE_WORD = 2'h2;
   // break selector encodings
   localparam logic [2:0]  STOP_NONE  = 3'h0;
   localparam logic [2:0]  STOP_A     = 3'h1;
   localparam logic [2:0]  STOP_A_OR  = 3'h2;
   localparam logic [2:0]  STOP_A_AND = 3'h3;
   localparam logic [2:0]  STOP_B_A   = 3'h4;
   typedef enum logic {OBT_MODE_BRANCH, OBT_MODE_DATA} obt_mode_t;
   typedef enum {OBT_RUN, OBT_HALT} obt_state_t;
endpackage : obt_pkg
`default_nettype wire
